// ### hdl/msal_top.sv
// Return stack, memory map, access lock and bootloader entry logic.
// Function
// RULE1: Four-level 16-bit return stack.
// RULE2: Calls, returns, interrupts, push, pop use stack.
// RULE3: Reset sets stack index to three.
// RULE4: Pushes increment index, then write entry.
// RULE5: Pops read entry, then decrement index.
// RULE6: Stack index wraps modulo four silently.
// RULE7: Utility ROM starts at address 8000h.
// RULE8: Harvard default, optional pseudo-Von Neumann map.
// RULE9: Optional map of program into data.
// RULE10: Password is program words 0010h to 001Fh.
// RULE11: Lock bit set refuses ROM without password.
// RULE12: Lock bit clear grants access freely.
// RULE13: Mass erase leaves an all-zero password.
// RULE14: Code lock denies access even with password.
// RULE15: Only mass erase clears code lock.
// RULE16: Program enable at reset starts bootloader.
// RULE17: Cleared program enable starts application.
// RULE18: Bootloader supports load, dump, checksum, verify, erase.
// RULE19: Sixteen 8-bit accumulators in module 9h.
// RULE20: Selector low nibble module, upper nibble index.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module msal_top (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [2:0]  stack_op,
   input  wire logic [15:0] stack_wdata,
   output logic      [15:0] stack_rdata,
   output logic      [1:0]  stack_index,
   input  wire logic [7:0]  reg_sel,
   input  wire logic        reg_we,
   input  wire logic [7:0]  reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic        pw_word_valid,
   input  wire logic [15:0] pw_word,
   output logic      [15:0] pw_fetch_addr,
   input  wire logic        host_pw_valid,
   input  wire logic [15:0] host_pw_word,
   input  wire logic        host_pw_start,
   input  wire logic        mass_erase_done,
   input  wire logic        code_lock_set,
   input  wire logic        jtag_pe_set,
   input  wire logic        jtag_pe_clear,
   input  wire logic        bl_op_valid,
   input  wire logic [2:0]  bl_op,
   output logic             bl_op_accept,
   output logic             urom_access_ok,
   output logic      [15:0] reset_vector,
   output logic      [1:0]  map_mode,
   output logic      [15:0] urom_base,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef struct packed {
      logic [msal_pkg::STACK_DEPTH-1:0][msal_pkg::STACK_WIDTH-1:0] stk;
      logic [1:0]                                            sp;
      logic [15:0]                                           srd;
      logic [msal_pkg::ACC_COUNT-1:0][msal_pkg::ACC_WIDTH-1:0]     acc;
      logic [15:0]                                           rrd;
      logic                                                  password_lock_bit;
      logic                                                  clk_lock;
      logic                                                  pe;
      logic                                                  boot;
      logic                                                  pw_ok;
      logic                                                  pw_match;
      logic [3:0]                                            pw_idx;
      msal_pkg::msal_pw_e                                    pw_st;
      logic                                                  blacc;
      logic [1:0]                                            map;
      logic                                                  aw_h;
      logic [7:0]                                            aw_a;
      logic                                                  w_h;
      logic [31:0]                                           w_d;
      logic                                                  bv;
      logic [1:0]                                            br;
      logic                                                  rv;
      logic [31:0]                                           rd;
      logic [1:0]                                            rr;
      logic                                                  first;
   } msal_state_s;

   msal_state_s s_q;
   msal_state_s s_d;
   logic        access_ok;

   // Access is granted unless code-locked; a set lock bit also needs the password.
   // RULE11 RULE12 RULE14 gate access.
   assign access_ok = ~s_q.clk_lock & (~s_q.password_lock_bit | s_q.pw_ok);

   // Next-state logic for every part of the block except the boot choice.
   always_comb begin
      s_d = s_q;
      s_d.blacc = 1'b0;
      s_d.first = 1'b0;
      // RULE2 RULE4 stack pushes.
      case (stack_op)
         msal_pkg::OP_CALL, msal_pkg::OP_PUSH, msal_pkg::OP_IRQ_VECTOR: begin
            // RULE6 silent wrap.
            s_d.sp = s_q.sp + msal_pkg::STACK_STEP;
            s_d.stk[s_d.sp] = stack_wdata;
         end
         // RULE5 read then decrement.
         msal_pkg::OP_RET, msal_pkg::OP_INTERRUPT_RETURN_OP, msal_pkg::OP_POP, msal_pkg::OP_STACK_LOAD_IRQ_OP: begin
            s_d.srd = s_q.stk[s_q.sp];
            s_d.sp  = s_q.sp - msal_pkg::STACK_STEP;
         end
         default: begin
         end
      endcase
      // RULE19 RULE20 register selector decode.
      s_d.rrd = 16'h0000;
      if (reg_sel[3:0] == msal_pkg::ACC_MODULE_SPEC) begin
         s_d.rrd = {8'h00, s_q.acc[reg_sel[7:4]]};
         if (reg_we) begin
            s_d.acc[reg_sel[7:4]] = reg_wdata;
         end
      end else if (reg_sel[3:0] == msal_pkg::SP_MODULE_SPEC &&
                   reg_sel[7:4] == msal_pkg::SP_REG_IDX) begin
         s_d.rrd = {14'h0000, s_q.sp};
      end
      // RULE10 RULE11 password compare over the sixteen words.
      case (s_q.pw_st)
         msal_pkg::MSAL_PW_IDLE: begin
            if (host_pw_start) begin
               s_d.pw_idx   = 4'h0;
               s_d.pw_match = 1'b1;
               s_d.pw_ok    = 1'b0;
               s_d.pw_st    = msal_pkg::MSAL_PW_CHECK;
            end
         end
         msal_pkg::MSAL_PW_CHECK: begin
            if (pw_word_valid && host_pw_valid) begin
               s_d.pw_match = s_q.pw_match & (pw_word == host_pw_word);
               s_d.pw_idx   = s_q.pw_idx + 4'h1;
               if (s_q.pw_idx == msal_pkg::PW_LAST_IDX) begin
                  s_d.pw_st = msal_pkg::MSAL_PW_DONE;
               end
            end
         end
         msal_pkg::MSAL_PW_DONE: begin
            s_d.pw_ok = s_q.pw_match;
            s_d.pw_st = msal_pkg::MSAL_PW_IDLE;
         end
         default: s_d.pw_st = msal_pkg::MSAL_PW_IDLE;
      endcase
      // RULE14 code lock set by the bootloader.
      if (code_lock_set) begin
         s_d.clk_lock = 1'b1;
      end
      // RULE13 RULE15 mass erase clears the lock; erased password is all zero.
      if (mass_erase_done && !code_lock_set) begin
         s_d.clk_lock = 1'b0;
         s_d.pw_ok    = 1'b0;
      end
      // RULE16 program enable from the debug port.
      if (jtag_pe_set) begin
         s_d.pe = 1'b1;
      end else if (jtag_pe_clear) begin
         s_d.pe = 1'b0;
      end
      // RULE18 bootloader operations need access.
      if (bl_op_valid && access_ok && bl_op <= msal_pkg::BL_ERASE) begin
         s_d.blacc = 1'b1;
      end
      // AXI write channel capture.
      if (s_axi_awvalid && !s_q.aw_h) begin
         s_d.aw_h = 1'b1;
         s_d.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_h) begin
         s_d.w_h = 1'b1;
         s_d.w_d = s_axi_wdata;
      end
      if (s_q.aw_h && s_q.w_h && !s_q.bv) begin
         s_d.aw_h = 1'b0;
         s_d.w_h  = 1'b0;
         s_d.bv   = 1'b1;
         s_d.br   = msal_pkg::AXI_OKAY;
         case (s_q.aw_a)
            msal_pkg::REG_CTRL: begin
               if (s_axi_wstrb[0]) begin
                  s_d.password_lock_bit = s_q.w_d[msal_pkg::CTRL_PWL_BIT];
               end
            end
            // RULE8 RULE9 map mode selection.
            msal_pkg::REG_MAP: begin
               if (s_axi_wstrb[0] && s_q.w_d[1:0] != 2'h3) begin
                  s_d.map = s_q.w_d[1:0];
               end
            end
            msal_pkg::REG_STATUS: begin
            end
            default: s_d.br = msal_pkg::AXI_SLVERR;
         endcase
      end
      if (s_q.bv && s_axi_bready) begin
         s_d.bv = 1'b0;
      end
      // AXI read channel.
      if (s_axi_arvalid && !s_q.rv) begin
         s_d.rv = 1'b1;
         s_d.rr = msal_pkg::AXI_OKAY;
         s_d.rd = 32'h0000_0000;
         case (s_axi_araddr)
            msal_pkg::REG_CTRL: begin
               s_d.rd[msal_pkg::CTRL_PWL_BIT] = s_q.password_lock_bit;
            end
            msal_pkg::REG_STATUS: begin
               s_d.rd[msal_pkg::CTRL_PWL_BIT]  = s_q.pw_ok;
               s_d.rd[msal_pkg::CTRL_LOCK_BIT] = s_q.clk_lock;
               s_d.rd[msal_pkg::CTRL_PE_BIT]   = s_q.pe;
               s_d.rd[5:4]                     = s_q.sp;
            end
            msal_pkg::REG_MAP: s_d.rd[1:0] = s_q.map;
            default: s_d.rr = msal_pkg::AXI_SLVERR;
         endcase
      end else if (s_q.rv && s_axi_rready) begin
         s_d.rv = 1'b0;
      end
   end

   // State register; the boot choice is latched just after reset release.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q          <= '0;
         // RULE3 stack index at the top.
         s_q.sp       <= msal_pkg::STACK_RESET_IDX;
         s_q.password_lock_bit      <= 1'b1;
         // Program enable and code lock survive reset, but a host clear or a mass erase
         // during reset still acts, which also gives both flops a known power-on value.
         s_q.pe       <= (s_q.pe & ~jtag_pe_clear) | jtag_pe_set;
         s_q.clk_lock <= s_q.clk_lock & ~mass_erase_done;
         s_q.map      <= msal_pkg::MAP_HARVARD;
         s_q.pw_st    <= msal_pkg::MSAL_PW_IDLE;
         s_q.first    <= 1'b1;
      end else begin
         s_q <= s_d;
         // RULE16 RULE17 choose bootloader or application.
         if (s_q.first) begin
            s_q.boot <= s_q.pe;
         end
      end
   end

   // Outputs driven only by flip-flops and constants, some through small combinational logic.
   assign stack_rdata    = s_q.srd;
   assign stack_index    = s_q.sp;
   assign reg_rdata      = s_q.rrd;
   assign pw_fetch_addr  = msal_pkg::PW_FIRST_ADDR + {12'h000, s_q.pw_idx};
   assign bl_op_accept   = s_q.blacc;
   assign urom_access_ok = ~s_q.clk_lock & (~s_q.password_lock_bit | s_q.pw_ok);
   // RULE7 utility ROM base and boot vector.
   assign reset_vector   = s_q.boot ? msal_pkg::UROM_BASE : msal_pkg::APP_RESET_ADDR;
   assign map_mode       = s_q.map;
   assign urom_base      = msal_pkg::UROM_BASE;
   assign s_axi_awready  = ~s_q.aw_h;
   assign s_axi_wready   = ~s_q.w_h;
   assign s_axi_bvalid   = s_q.bv;
   assign s_axi_bresp    = s_q.br;
   assign s_axi_arready  = ~s_q.rv;
   assign s_axi_rvalid   = s_q.rv;
   assign s_axi_rdata    = s_q.rd;
   assign s_axi_rresp    = s_q.rr;

   AST_RESET_IDX: assert property (@(posedge clk) $fell(reset) |-> stack_index == 2'h3) // RULE3
      else $error("stack index not three after reset");
   AST_PUSH_INC: assert property (@(posedge clk) disable iff (reset)
      stack_op inside {3'h1, 3'h2, 3'h3} |=> stack_index == $past(stack_index) + 2'h1) // RULE4
      else $error("push did not increment index");
   AST_POP_DEC: assert property (@(posedge clk) disable iff (reset)
      stack_op[2] |=> stack_index == $past(stack_index) - 2'h1) // RULE5
      else $error("pop did not decrement index");
   AST_PUSH_POP: assert property (@(posedge clk) disable iff (reset)
      stack_op == 3'h2 ##1 stack_op == 3'h6 |=> stack_rdata == $past(stack_wdata, 2)) // RULE1
      else $error("pop did not return pushed value");
   AST_LOCK_DENY: assert property (@(posedge clk) disable iff (reset)
      s_q.clk_lock |-> !urom_access_ok) // RULE14
      else $error("code lock did not deny access");
   AST_PWL_FREE: assert property (@(posedge clk) disable iff (reset)
      !s_q.password_lock_bit && !s_q.clk_lock |-> urom_access_ok) // RULE12
      else $error("clear lock bit did not grant access");
   AST_BL_DENY: assert property (@(posedge clk) disable iff (reset)
      bl_op_valid && !urom_access_ok |=> !bl_op_accept) // RULE11
      else $error("bootloader op accepted while locked");
   AST_ERASE_CLR: assert property (@(posedge clk) disable iff (reset)
      mass_erase_done && !code_lock_set |=> !s_q.clk_lock) // RULE15
      else $error("mass erase did not clear code lock");
   AST_BOOT_VEC: assert property (@(posedge clk) disable iff (reset)
      s_q.boot |-> reset_vector == 16'h8000) // RULE16
      else $error("boot vector not utility ROM");
   COV_PUSH_POP: cover property (@(posedge clk) stack_op == 3'h1 ##1 stack_op == 3'h4);
   COV_PW_OK: cover property (@(posedge clk) $rose(s_q.pw_ok));
   COV_BOOT: cover property (@(posedge clk) $rose(s_q.boot));
endmodule

// ### include/msal_pkg.sv
// Package with constants for the memory stack and access lock block.
package msal_pkg;
   localparam int          STACK_DEPTH      = 4;
   localparam int          STACK_WIDTH      = 16;
   localparam logic [1:0]  STACK_RESET_IDX  = 2'h3;
   localparam logic [1:0]  STACK_STEP       = 2'h1;
   localparam logic [15:0] UROM_BASE        = 16'h8000;
   localparam logic [15:0] APP_RESET_ADDR   = 16'h0000;
   localparam logic [15:0] PW_FIRST_ADDR    = 16'h0010;
   localparam logic [15:0] PW_LAST_ADDR     = 16'h001f;
   localparam logic [15:0] PW_ERASED_WORD   = 16'h0000;
   localparam logic [3:0]  PW_LAST_IDX      = 4'hf;
   localparam int          PW_WORDS         = 16;
   localparam int          ACC_COUNT        = 16;
   localparam int          ACC_WIDTH        = 8;
   localparam logic [3:0]  ACC_MODULE_SPEC  = 4'h9;
   localparam logic [3:0]  SP_MODULE_SPEC   = 4'hd;
   localparam logic [3:0]  SP_REG_IDX       = 4'h1;
   // AXI register byte offsets.
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_STATUS       = 8'h04;
   localparam logic [7:0]  REG_MAP          = 8'h08;
   // Control and status register fields.
   localparam int          CTRL_PWL_BIT     = 0;
   localparam int          CTRL_LOCK_BIT    = 1;
   localparam int          CTRL_PE_BIT      = 2;
   // Memory map modes.
   localparam logic [1:0]  MAP_HARVARD      = 2'h0;
   localparam logic [1:0]  MAP_VON_NEUMANN  = 2'h1;
   localparam logic [1:0]  MAP_PROG_IN_DATA = 2'h2;
   // Stack operation codes.
   localparam logic [2:0]  OP_NONE          = 3'h0;
   localparam logic [2:0]  OP_CALL          = 3'h1;
   localparam logic [2:0]  OP_PUSH          = 3'h2;
   localparam logic [2:0]  OP_IRQ_VECTOR    = 3'h3;
   localparam logic [2:0]  OP_RET           = 3'h4;
   localparam logic [2:0]  OP_INTERRUPT_RETURN_OP          = 3'h5;
   localparam logic [2:0]  OP_POP           = 3'h6;
   localparam logic [2:0]  OP_STACK_LOAD_IRQ_OP          = 3'h7;
   // Bootloader operations.
   localparam logic [2:0]  BL_LOAD          = 3'h0;
   localparam logic [2:0]  BL_DUMP          = 3'h1;
   localparam logic [2:0]  BL_CHECKSUM      = 3'h2;
   localparam logic [2:0]  BL_VERIFY        = 3'h3;
   localparam logic [2:0]  BL_ERASE         = 3'h4;
   localparam logic [1:0]  AXI_OKAY         = 2'h0;
   localparam logic [1:0]  AXI_SLVERR       = 2'h2;
   typedef enum logic [1:0] {
      MSAL_PW_IDLE  = 2'h0,
      MSAL_PW_CHECK = 2'h1,
      MSAL_PW_DONE  = 2'h3
   } msal_pw_e;
endpackage

// ### tb/msal_host_model.sv
// Programmer-side model: password words in program memory and host JTAG actions.
`timescale 1ns/1ps
module msal_host_model (
   input  wire logic        clk,
   input  wire logic [15:0] pw_fetch_addr,
   output logic             pw_word_valid,
   output logic      [15:0] pw_word,
   output logic             host_pw_start,
   output logic             host_pw_valid,
   output logic      [15:0] host_pw_word,
   output logic             jtag_pe_set,
   output logic             jtag_pe_clear,
   output logic             mass_erase_done
);
   logic [15:0] pmem [16];
   logic        flip_q = 1'b0;

   // Toggles every cycle so that an undriven word never repeats a value.
   always @(posedge clk) flip_q <= ~flip_q;

   // password word fetch
   // Only the sixteen key words are answered; other addresses see noise.
   always_comb begin
      pw_word_valid = pw_fetch_addr[15:4] == 12'h001;
      pw_word       = pw_word_valid ? pmem[pw_fetch_addr[3:0]] : {16{flip_q}};
   end

   // Host lines idle low from time zero.
   initial begin
      host_pw_start   = 1'b0;
      host_pw_valid   = 1'b0;
      host_pw_word    = 16'h0000;
      jtag_pe_set     = 1'b0;
      jtag_pe_clear   = 1'b0;
      mass_erase_done = 1'b0;
   end

   // host supplies password
   // A bad key differs from the stored one only in its last word.
   task automatic send_pw(input bit good);
      @(posedge clk);
      host_pw_start <= 1'b1;
      @(posedge clk);
      host_pw_start <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         host_pw_valid <= 1'b1;
         host_pw_word  <= pmem[i] ^ {15'h0000, !good && i == 15};
         @(posedge clk);
      end
      host_pw_valid <= 1'b0;
      host_pw_word  <= ~host_pw_word;
   endtask

   task automatic pe_pulse(input bit set);
      @(posedge clk);
      jtag_pe_set   <= set;
      jtag_pe_clear <= !set;
      @(posedge clk);
      jtag_pe_set   <= 1'b0;
      jtag_pe_clear <= 1'b0;
   endtask

   task automatic erase();
      @(posedge clk);
      for (int i = 0; i < 16; i++) pmem[i] = 16'h0000;
      mass_erase_done <= 1'b1;
      @(posedge clk);
      mass_erase_done <= 1'b0;
   endtask
endmodule

// ### tb/test_msal_top.sv
// Self-checking bench for the memory stack and access lock block.
`timescale 1ns/1ps
`define CHK(a, b) begin \
   tests_run++; \
   if ((a) !== (b)) begin \
      err_total++; \
      $display("[ERR] %0t got %h want %h", $time, a, b); \
   end \
end
module test_msal_top;
   logic        clk = 1'b0, reset = 1'b1, reg_we = 1'b0, code_lock_set = 1'b0;
   logic        bl_op_valid = 1'b0, bl_op_accept, urom_access_ok, pw_word_valid;
   logic        host_pw_valid, host_pw_start, mass_erase_done, jtag_pe_set, jtag_pe_clear;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [2:0]  stack_op = 3'h0, bl_op = 3'h0;
   logic [15:0] stack_wdata = 16'h0000, stack_rdata, reg_rdata, pw_word, pw_fetch_addr;
   logic [15:0] host_pw_word, reset_vector, urom_base, val [4];
   logic [1:0]  stack_index, map_mode, s_axi_bresp, s_axi_rresp, rsv;
   logic [7:0]  reg_sel = 8'h00, reg_wdata = 8'h00, s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00, acc [16];
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb = 4'hf;
   int          err_total = 0, tests_run = 0, seed = 32'hff332f7a;

   msal_top u_dut (.*);
   msal_host_model u_host (.*);

   // Free-running 25 MHz clock.
   always #20 clk = ~clk;

   // Stack index expected after the j-th operation of the stack sequence.
   function automatic logic [1:0] exp_idx(input int j);
      return j < 4 ? 2'(j) : 2'(6 - j);
   endfunction

   // One AXI4-Lite transfer; sampled at falling edges, driven after rising ones.
   task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [1:0] rs);
      bit ta, tw, tr, done;
      done = 1'b0;
      @(posedge clk);
      if (wr) begin
         s_axi_awaddr  <= a;
         s_axi_wdata   <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid  <= 1'b1;
         s_axi_bready  <= 1'b1;
      end else begin
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready  <= 1'b1;
      end
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
         rd = s_axi_rdata;
         rs = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (done) s_axi_bready <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
      end
      if (!done) begin
         err_total++;
         $display("[ERR] %0t no bus answer", $time);
      end
   endtask

   // Offers all five loader operations and checks each acceptance pulse.
   task automatic bl_try(input logic ok);
      for (int op = 0; op < 5; op++) begin
         @(posedge clk);
         bl_op_valid <= 1'b1;
         bl_op       <= 3'(op);
         @(posedge clk);
         bl_op_valid <= 1'b0;
         @(negedge clk);
         `CHK(bl_op_accept, ok)
      end
   endtask

   // Reset for five cycles, or seven with program enable raised inside it.
   task automatic do_reset(input bit pe);
      @(posedge clk);
      reset <= 1'b1;
      if (pe) u_host.pe_pulse(1'b1);
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // Waits a bounded time for access to open after a key was sent.
   task automatic wait_ok();
      for (int n = 0; n < 40 && urom_access_ok !== 1'b1; n++) @(negedge clk);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // The sequence needs a few hundred cycles; fifty thousand means a hang.
   initial begin
      #2000000;
      err_total++;
      $display("[ERR] %0t run hung", $time);
      complete_run();
   end

   initial begin
      // Power-on inside the five reset cycles: erase clears the code lock, then pe is cleared.
      u_host.erase();
      u_host.pe_pulse(1'b0);
      @(posedge clk);
      for (int i = 0; i < 16; i++) u_host.pmem[i] = 16'($random(seed));
      for (int i = 0; i < 16; i++) acc[i] = 8'($random(seed));
      for (int i = 0; i < 4; i++) val[i] = 16'($random(seed));
      reset <= 1'b0;
      @(negedge clk);
      `CHK(stack_index, msal_pkg::STACK_RESET_IDX)
      `CHK(urom_base, msal_pkg::UROM_BASE)
      `CHK(map_mode, msal_pkg::MAP_HARVARD)
      axi(1'b0, msal_pkg::REG_CTRL, 32'h0, rdv, rsv);
      `CHK(rdv[0], 1'b1)
      $display("reset test done");
      // Four pushes wrap the index, four pops read back in reverse and wrap.
      for (int j = 0; j < 9; j++) begin
         @(posedge clk);
         stack_op    <= j > 7 ? 3'h0 : 3'(j == 3 ? 2 : (j < 4 ? j + 1 : j));
         stack_wdata <= val[j % 4];
         @(negedge clk);
         if (j > 0) `CHK(stack_index, exp_idx(j - 1))
         if (j > 4) `CHK(stack_rdata, val[8 - j])
      end
      @(posedge clk);
      reg_sel <= {msal_pkg::SP_REG_IDX, msal_pkg::SP_MODULE_SPEC};
      @(posedge clk);
      @(negedge clk);
      `CHK(reg_rdata, 16'h0003)
      $display("stack test done");
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         reg_we    <= 1'b1;
         reg_sel   <= {4'(i), msal_pkg::ACC_MODULE_SPEC};
         reg_wdata <= acc[i];
      end
      for (int i = 0; i < 17; i++) begin
         @(posedge clk);
         reg_we  <= 1'b0;
         reg_sel <= {4'(i), msal_pkg::ACC_MODULE_SPEC};
         @(negedge clk);
         if (i > 0) `CHK(reg_rdata, {8'h00, acc[i - 1]})
      end
      $display("accumulator test done");
      for (int m = 0; m < 4; m++) begin
         axi(1'b1, msal_pkg::REG_MAP, 32'(m), rdv, rsv);
         @(negedge clk);
         `CHK(map_mode, m < 3 ? 2'(m) : msal_pkg::MAP_PROG_IN_DATA)
      end
      axi(1'b1, 8'h0c, 32'h1, rdv, rsv);
      `CHK(rsv, msal_pkg::AXI_SLVERR)
      axi(1'b0, 8'h0c, 32'h0, rdv, rsv);
      `CHK(rsv, msal_pkg::AXI_SLVERR)
      $display("map test done");
      bl_try(1'b0);
      u_host.send_pw(1'b0);
      repeat (4) @(negedge clk);
      `CHK(urom_access_ok, 1'b0)
      u_host.send_pw(1'b1);
      wait_ok();
      `CHK(urom_access_ok, 1'b1)
      bl_try(1'b1);
      @(posedge clk);
      code_lock_set <= 1'b1;
      @(posedge clk);
      code_lock_set <= 1'b0;
      axi(1'b1, msal_pkg::REG_CTRL, 32'h0, rdv, rsv);
      bl_try(1'b0);
      do_reset(1'b0);
      axi(1'b0, msal_pkg::REG_STATUS, 32'h0, rdv, rsv);
      `CHK(rdv[1], 1'b1)
      u_host.erase();
      axi(1'b1, msal_pkg::REG_CTRL, 32'h0, rdv, rsv);
      axi(1'b0, msal_pkg::REG_STATUS, 32'h0, rdv, rsv);
      `CHK(rdv[1:0], 2'b00)
      bl_try(1'b1);
      axi(1'b1, msal_pkg::REG_CTRL, 32'h1, rdv, rsv);
      bl_try(1'b0);
      u_host.send_pw(1'b1);
      wait_ok();
      `CHK(urom_access_ok, 1'b1)
      $display("lock test done");
      do_reset(1'b1);
      `CHK(reset_vector, msal_pkg::UROM_BASE)
      u_host.pe_pulse(1'b0);
      do_reset(1'b0);
      `CHK(reset_vector, msal_pkg::APP_RESET_ADDR)
      $display("boot test done");
      complete_run();
   end
endmodule
